// ==== hw/hsf_pkg.sv ====
package hsf_pkg;

    // ------------------------------------------------------------
    // buffer geometry
    // ------------------------------------------------------------
    localparam int HSF_HALF_BYTES = 32;    // bytes in one half
    localparam int HSF_BUF_BYTES = 64;     // bytes in both halves
    localparam int HSF_MAX_FRAMES = 17;    // bound of the received-frame tally
    localparam logic [5:0] HSF_CNT_RST = 6'h00;

    // ------------------------------------------------------------
    // serial-side receive write
    // ------------------------------------------------------------
    typedef struct packed {
        logic valid;      // one byte offered
        logic [7:0] data; // control field, data or status byte
        logic last;       // byte is the appended status byte
    } hsf_rx_byte_t;

    // host-side command strobes
    typedef struct packed {
        logic rx_block_done_cmd;     // release the host-side receive half
        logic tx_end_of_message_cmd; // frame end given by host
        logic tx_reset_cmd;          // flush the transmit buffer
    } hsf_cmd_t;

endpackage : hsf_pkg

// ==== hw/hsf_buffer.sv ====
`timescale 1ns/1ps
// How it works
// - each direction holds 64 bytes as two 32-byte halves, one host-visible
// - a whole received frame of up to 64 bytes fits in the buffer
// - a filled receive half raises pool-full irq or rx dma request
// - interrupt mode keeps the half until the block-done command arrives
// - dma mode releases the receive half once all of its bytes are read, at most 32
// - interrupt-mode reads do not consume; each read advances the read pointer, with no rewind
// - long frames keep requesting successive 32-byte blocks until frame ends
// - at most 2 short frames are held in the receive buffer, one per half
// - a closed serial half takes no further frame until the host half is released
// - address dropped, control first, status byte appended by the serial side
// - dma request stays up while transfers are needed, drops after block
// - each dma block is at most 32 bytes
// - transmit-pool-ready flags an empty host-accessible transmit half after a reset command or an interrupt-mode hand-over
// - dma request drops at the clock edge that ends the final cycle of the block
// - underrun fires when transmit empties without end-of-message
module hsf_buffer
    import hsf_pkg::*;
#(
    parameter int HALF = 32 // bytes per half
) (
    input wire logic clk_i,                          // 100 mhz system clock
    input wire logic reset_n_i,                      // async active-low reset
    input wire logic dma_mode_i,                     // 1: dma, 0: interrupt mode
    input wire hsf_pkg::hsf_rx_byte_t rx_wr_i,       // serial side receive byte
    input wire hsf_pkg::hsf_cmd_t cmd_i,             // command register strobes
    input wire logic rx_rd_i,                        // host read of receive half
    input wire logic dma_acknowledge_i,              // dma cycle start
    output logic [7:0] rx_data_o,                    // receive read data
    output logic rx_pool_full_irq_o,                 // receive half ready pulse
    output logic rx_dma_request_o,                   // receive dma request level
    input wire logic tx_wr_i,                        // host write to transmit half
    input wire logic [7:0] tx_wdata_i,               // transmit write data
    input wire logic [15:0] tx_byte_count_i,         // dma-mode frame length
    input wire logic tx_ser_rd_i,                    // serial side takes a byte
    output logic [7:0] tx_ser_data_o,                // byte to serialiser
    output logic tx_ser_valid_o,                     // serial byte available
    output logic tx_ser_last_o,                      // byte ends the frame
    output logic tx_pool_ready_irq_o,                // transmit half free pulse
    output logic tx_dma_request_o,                   // transmit dma request level
    output logic tx_underrun_irq_o,                  // underrun pulse
    output logic rx_overflow_o                       // serial byte dropped
);
    import hsf_pkg::*;

    localparam int AW = $clog2(2 * HALF);
    localparam int HW = $clog2(HALF);

    // ------------------------------------------------------------
    // receive buffer
    // ------------------------------------------------------------
    logic [7:0] rx_mem [0:2*HALF-1];
    logic rx_host_reg;          // half index owned by host
    logic [1:0] rx_full_reg;    // half is closed and waiting
    logic [HW:0] rx_wcnt_reg;   // bytes in serial half
    logic [HW:0] rx_fill_reg [0:1]; // bytes held per half
    logic [HW-1:0] rx_rptr_reg; // read pointer in host half
    logic [HW:0] rx_dma_cnt_reg;
    logic [4:0] rx_frames_reg;  // frames received, saturates at 17
    logic rx_dma_req_reg;
    logic rx_irq_reg;
    logic [7:0] rx_data_reg;
    logic rx_ovf_reg;

    wire rx_ser_half = ~rx_host_reg;
    // a frame end closes the serial half so short frames queue
    wire rx_can_wr = ~rx_full_reg[rx_ser_half] && (rx_wcnt_reg < (HW+1)'(HALF));
    wire rx_take = rx_wr_i.valid & rx_can_wr;
    wire rx_close = rx_take & (rx_wr_i.last | (rx_wcnt_reg == (HW+1)'(HALF - 1)));
    wire rx_host_ready = rx_full_reg[rx_host_reg];
    wire rx_dma_rd = dma_mode_i & dma_acknowledge_i & rx_dma_req_reg;
    wire rx_rd = rx_host_ready & (rx_rd_i | rx_dma_rd);
    wire [HW:0] rx_host_fill = rx_fill_reg[rx_host_reg];
    // dma releases after the block is read out; at most 32 bytes
    wire rx_dma_done = rx_dma_rd & (rx_dma_cnt_reg + 1'b1 == rx_host_fill);
    wire rx_release = rx_host_ready &
                      ((~dma_mode_i & cmd_i.rx_block_done_cmd) | rx_dma_done);
    wire [AW-1:0] rx_waddr = {rx_ser_half, rx_wcnt_reg[HW-1:0]};
    wire [AW-1:0] rx_raddr = {rx_host_reg, rx_rptr_reg};

    // serial-side writes and half closing
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rx_wcnt_reg <= '0;
            rx_full_reg <= 2'b00;
            rx_host_reg <= 1'b0;
            rx_frames_reg <= '0;
            rx_fill_reg[0] <= '0;
            rx_fill_reg[1] <= '0;
            rx_ovf_reg <= 1'b0;
        end else begin
            rx_ovf_reg <= rx_wr_i.valid & ~rx_can_wr;
            if (rx_take) begin
                rx_mem[rx_waddr] <= rx_wr_i.data; // status byte stored as given
                rx_wcnt_reg <= rx_close ? '0 : rx_wcnt_reg + 1'b1;
            end
            if (rx_close) begin
                rx_full_reg[rx_ser_half] <= 1'b1;
                rx_fill_reg[rx_ser_half] <= rx_wcnt_reg + 1'b1;
            end
            if (rx_release) begin
                rx_full_reg[rx_host_reg] <= 1'b0;
                rx_host_reg <= ~rx_host_reg;      // swap halves
            end else if (!rx_host_ready && rx_close) begin
                rx_host_reg <= rx_ser_half;       // first block goes straight to host
            end
            // frame tally bounded by 17
            if (rx_take && rx_wr_i.last && rx_frames_reg < 5'(HSF_MAX_FRAMES))
                rx_frames_reg <= rx_frames_reg + 1'b1;
        end
    end

    // host-side reads; interrupt mode never consumes
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rx_rptr_reg <= '0;
            rx_dma_cnt_reg <= '0;
            rx_data_reg <= 8'h00;
        end else begin
            if (rx_rd) begin
                rx_data_reg <= rx_mem[rx_raddr];
                rx_rptr_reg <= rx_rptr_reg + 1'b1;
            end
            if (rx_dma_rd)
                rx_dma_cnt_reg <= rx_dma_cnt_reg + 1'b1;
            if (rx_release) begin
                rx_rptr_reg <= '0;
                rx_dma_cnt_reg <= '0;
            end
        end
    end

    // prompt per filled half; long frames repeat per block
    wire rx_new_block = rx_close & ~rx_host_ready;
    wire rx_next_block = rx_release & rx_full_reg[~rx_host_reg];
    // request drops at the edge that ends the final read cycle
    wire rx_req_next = dma_mode_i & rx_host_ready & ~rx_release & ~rx_dma_done;
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rx_irq_reg <= 1'b0;
            rx_dma_req_reg <= 1'b0;
        end else begin
            rx_irq_reg <= ~dma_mode_i & (rx_new_block | rx_next_block);
            // a queued block re-raises the request one cycle after the release
            rx_dma_req_reg <= rx_req_next | (dma_mode_i & rx_new_block);
        end
    end
    // the far side gates this request with its strobe

    // ------------------------------------------------------------
    // transmit buffer
    // ------------------------------------------------------------
    logic [7:0] tx_mem [0:2*HALF-1];
    logic tx_host_reg;          // half the host fills
    logic [1:0] tx_full_reg;    // half handed to serial side
    logic [HW:0] tx_wcnt_reg;
    logic [HW:0] tx_fill_reg [0:1];
    logic [1:0] tx_eom_reg;     // half ends the frame
    logic [HW:0] tx_rcnt_reg;
    logic [15:0] tx_sent_reg;   // bytes sent in dma frame
    logic tx_active_reg;
    logic tx_xpr_reg, tx_dma_req_reg, tx_xdu_reg;
    logic [7:0] tx_sdata_reg;
    logic tx_svalid_reg, tx_slast_reg;

    wire tx_ser_half = ~tx_host_reg;
    wire tx_dma_wr = dma_mode_i & dma_acknowledge_i & tx_dma_req_reg;
    wire tx_wr = (tx_wr_i | tx_dma_wr) & ~tx_full_reg[tx_host_reg] &
                 (tx_wcnt_reg < (HW+1)'(HALF));
    wire tx_dma_end = (tx_sent_reg + 16'(tx_wcnt_reg) + 16'h0001) >= tx_byte_count_i;
    wire tx_hand = (tx_wr & tx_dma_wr & ((tx_wcnt_reg == (HW+1)'(HALF - 1)) | tx_dma_end))
                 | (~dma_mode_i & cmd_i.tx_end_of_message_cmd);
    wire tx_hand_eom = cmd_i.tx_end_of_message_cmd | (tx_dma_wr & tx_dma_end);
    wire tx_has = tx_full_reg[tx_ser_half] & (tx_rcnt_reg < tx_fill_reg[tx_ser_half]);
    wire tx_pop = tx_has & tx_ser_rd_i;
    wire tx_half_empty = tx_pop & (tx_rcnt_reg + 1'b1 == tx_fill_reg[tx_ser_half]);
    wire tx_eom_now = tx_eom_reg[tx_ser_half];
    // empty without an end-of-message marker
    wire tx_underrun = tx_active_reg & tx_ser_rd_i & ~tx_has & ~tx_full_reg[tx_host_reg];

    // host and dma writes, hand-over to serial side
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            tx_host_reg <= 1'b0;
            tx_full_reg <= 2'b00;
            tx_wcnt_reg <= '0;
            tx_fill_reg[0] <= '0;
            tx_fill_reg[1] <= '0;
            tx_eom_reg <= 2'b00;
            tx_rcnt_reg <= '0;
            tx_sent_reg <= 16'h0000;
            tx_active_reg <= 1'b0;
        end else if (cmd_i.tx_reset_cmd) begin
            tx_full_reg <= 2'b00;
            tx_wcnt_reg <= '0;
            tx_rcnt_reg <= '0;
            tx_sent_reg <= 16'h0000;
            tx_active_reg <= 1'b0;
        end else begin
            if (tx_wr)
                tx_mem[{tx_host_reg, tx_wcnt_reg[HW-1:0]}] <= tx_wdata_i;
            if (tx_wr && !tx_hand)
                tx_wcnt_reg <= tx_wcnt_reg + 1'b1;
            if (tx_hand && !tx_full_reg[tx_ser_half]) begin
                tx_full_reg[tx_host_reg] <= 1'b1;
                tx_fill_reg[tx_host_reg] <= tx_wcnt_reg + (HW+1)'(tx_wr);
                tx_eom_reg[tx_host_reg] <= tx_hand_eom;
                tx_sent_reg <= tx_hand_eom ? 16'h0000 : tx_sent_reg + 16'(tx_wcnt_reg) + 16'h0001;
                tx_host_reg <= ~tx_host_reg;      // swap halves
                tx_wcnt_reg <= '0;
                tx_active_reg <= 1'b1;
            end
            if (tx_pop)
                tx_rcnt_reg <= tx_half_empty ? '0 : tx_rcnt_reg + 1'b1;
            if (tx_half_empty) begin
                tx_full_reg[tx_ser_half] <= 1'b0;
                if (tx_eom_now)
                    tx_active_reg <= 1'b0;
            end
            if (tx_underrun)
                tx_active_reg <= 1'b0;
        end
    end

    // transmit flags and serial output
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            tx_xpr_reg <= 1'b0;
            tx_dma_req_reg <= 1'b0;
            tx_xdu_reg <= 1'b0;
            tx_sdata_reg <= 8'h00;
            tx_svalid_reg <= 1'b0;
            tx_slast_reg <= 1'b0;
        end else begin
            tx_xpr_reg <= cmd_i.tx_reset_cmd | (tx_hand & ~dma_mode_i);
            tx_dma_req_reg <= dma_mode_i & ~cmd_i.tx_reset_cmd & ~tx_hand &
                              ~tx_full_reg[tx_host_reg] &
                              (tx_sent_reg < tx_byte_count_i);
            tx_xdu_reg <= tx_underrun;
            tx_svalid_reg <= tx_pop;
            if (tx_pop) begin
                tx_sdata_reg <= tx_mem[{tx_ser_half, tx_rcnt_reg[HW-1:0]}];
                tx_slast_reg <= tx_half_empty & tx_eom_now;
            end
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign rx_data_o = rx_data_reg;
    assign rx_pool_full_irq_o = rx_irq_reg;
    assign rx_dma_request_o = rx_dma_req_reg;
    assign rx_overflow_o = rx_ovf_reg;
    assign tx_ser_data_o = tx_sdata_reg;
    assign tx_ser_valid_o = tx_svalid_reg;
    assign tx_ser_last_o = tx_slast_reg;
    assign tx_pool_ready_irq_o = tx_xpr_reg;
    assign tx_dma_request_o = tx_dma_req_reg;
    assign tx_underrun_irq_o = tx_xdu_reg;

endmodule : hsf_buffer

// ==== verif/hsf_buffer_asserts.sv ====
`timescale 1ns/1ps
// --------------------------------------------
// handshake checks on the buffer ports
// --------------------------------------------
module hsf_buffer_chk
    import hsf_pkg::*;
#(
    parameter int HALF = 32 // bytes per half
) (
    input wire logic clk_i, // clock
    input wire logic reset_n_i, // reset
    input wire logic dma_mode_i, // mode
    input wire hsf_pkg::hsf_cmd_t cmd_i, // commands
    input wire logic dma_acknowledge_i, // dma cycle
    input wire logic rx_pool_full_irq_o, // rx irq
    input wire logic rx_dma_request_o, // rx request
    input wire logic tx_ser_rd_i, // serial take
    input wire logic tx_ser_valid_o, // serial byte
    input wire logic tx_pool_ready_irq_o, // tx ready
    input wire logic tx_underrun_irq_o // underrun
);
    import hsf_pkg::*;
    logic [6:0] ack_cnt; // acks within one request
    default clocking @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);
    // count acknowledges while the request stands
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            ack_cnt <= 7'h00;
        end else if (!rx_dma_request_o) begin
            ack_cnt <= 7'h00;
        end else if (dma_acknowledge_i) begin
            ack_cnt <= ack_cnt + 7'h01;
        end
    end
    property p_irq_pulse; rx_pool_full_irq_o |=> !rx_pool_full_irq_o; endproperty
    a_irq_pulse: assert property (p_irq_pulse) else $error("rx irq too long");
    property p_irq_mode; rx_pool_full_irq_o |-> !dma_mode_i; endproperty
    a_irq_mode: assert property (p_irq_mode) else $error("rx irq in dma mode");
    property p_req_mode; rx_dma_request_o |-> dma_mode_i; endproperty
    a_req_mode: assert property (p_req_mode) else $error("request in irq mode");
    property p_req_hold;
        rx_dma_request_o && !dma_acknowledge_i && !$past(dma_acknowledge_i) |=> rx_dma_request_o;
    endproperty
    a_req_hold: assert property (p_req_hold) else $error("request dropped early");
    property p_req_len; ack_cnt <= HALF; endproperty
    a_req_len: assert property (p_req_len) else $error("dma block too long");
    property p_req_drop;
        rx_dma_request_o && dma_acknowledge_i && ack_cnt == HALF - 1 |-> ##[1:2] !rx_dma_request_o;
    endproperty
    a_req_drop: assert property (p_req_drop) else $error("request kept");
    property p_tx_rst; cmd_i.tx_reset_cmd |-> ##[1:3] tx_pool_ready_irq_o; endproperty
    a_tx_rst: assert property (p_tx_rst) else $error("no tx ready");
    property p_tx_ser; tx_ser_valid_o |-> $past(tx_ser_rd_i); endproperty
    a_tx_ser: assert property (p_tx_ser) else $error("unasked tx byte");
    property p_under; tx_underrun_irq_o |-> $past(tx_ser_rd_i) && !tx_ser_valid_o; endproperty
    a_under: assert property (p_under) else $error("bad underrun");
    c_irq: cover property (rx_pool_full_irq_o);
    c_drop: cover property (rx_dma_request_o && dma_acknowledge_i && ack_cnt == HALF - 1);
    c_rdy: cover property (tx_pool_ready_irq_o);
endmodule : hsf_buffer_chk
bind hsf_buffer hsf_buffer_chk #(.HALF(HALF)) u_chk (.clk_i(clk_i), .reset_n_i(reset_n_i),
    .dma_mode_i(dma_mode_i), .cmd_i(cmd_i), .dma_acknowledge_i(dma_acknowledge_i),
    .rx_pool_full_irq_o(rx_pool_full_irq_o), .rx_dma_request_o(rx_dma_request_o),
    .tx_ser_rd_i(tx_ser_rd_i), .tx_ser_valid_o(tx_ser_valid_o),
    .tx_pool_ready_irq_o(tx_pool_ready_irq_o), .tx_underrun_irq_o(tx_underrun_irq_o));

// ==== verif/hsf_dma_model.sv ====
`timescale 1ns/1ps
module hsf_dma_model (
    input wire logic clk_i, // clock
    input wire logic reset_n_i, // reset
    input wire logic req_i, // rx request
    input wire logic [7:0] data_i, // rx data
    input wire logic [3:0] gap_i, // extra idle cycles
    output logic ack_o, // one read cycle
    output logic [7:0] byte_o, // fetched byte
    output logic byte_valid_o // byte_o fresh
);
    logic ack_d; // read under way
    logic [4:0] quiet; // cycles before next look
    // one read at a time, request qualified by our own strobe
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            ack_o <= 1'b0;
            ack_d <= 1'b0;
            quiet <= 5'h00;
            byte_o <= 8'h00;
            byte_valid_o <= 1'b0;
        end else begin
            ack_d <= ack_o;
            byte_valid_o <= ack_d;
            byte_o <= data_i;
            if (ack_o) begin
                ack_o <= 1'b0;
            end else if (quiet != 5'h00) begin
                quiet <= quiet - 5'h01;
            end else if (req_i) begin
                ack_o <= 1'b1;
                quiet <= 5'h02 + {1'b0, gap_i};
            end
        end
    end
endmodule : hsf_dma_model

// ==== verif/hsf_buffer_tb.sv ====
`timescale 1ns/1ps
module hsf_buffer_tb;
    import hsf_pkg::*;
    typedef struct {logic dma; int len; int gap; logic irq; logic req;} hsf_row_t;
    hsf_row_t rows [5] = '{'{1'b0, 2, 0, 1'b1, 1'b0}, '{1'b0, 32, 0, 1'b1, 1'b0},
        '{1'b1, 1, 0, 1'b0, 1'b1}, '{1'b1, 32, 3, 1'b0, 1'b1}, '{1'b1, 40, 1, 1'b0, 1'b1}};
    logic clk = 1'b0;
    logic reset_n = 1'b1;
    logic dma_mode = 1'b0;
    logic rx_rd = 1'b0;
    logic tx_wr = 1'b0;
    logic tx_rd = 1'b0;
    logic [7:0] tx_wdata = 8'h00;
    logic [3:0] gap = 4'h0;
    hsf_rx_byte_t rx_wr = '0;
    hsf_cmd_t cmd = '0;
    logic ack, irq, req, ovf, rdy, txv, txl, und, txq, bv, si, sr;
    logic [7:0] rdata, txd, bd;
    int mismatches = 0;
    int checks_done = 0;
    int cycles = 0;
    hsf_buffer #(.HALF(32)) dut (.clk_i(clk), .reset_n_i(reset_n), .dma_mode_i(dma_mode),
        .rx_wr_i(rx_wr), .cmd_i(cmd), .rx_rd_i(rx_rd), .dma_acknowledge_i(ack),
        .rx_data_o(rdata), .rx_pool_full_irq_o(irq), .rx_dma_request_o(req), .tx_wr_i(tx_wr),
        .tx_wdata_i(tx_wdata), .tx_byte_count_i(16'h0020), .tx_ser_rd_i(tx_rd),
        .tx_ser_data_o(txd), .tx_ser_valid_o(txv), .tx_ser_last_o(txl),
        .tx_pool_ready_irq_o(rdy), .tx_dma_request_o(txq), .tx_underrun_irq_o(und),
        .rx_overflow_o(ovf));
    hsf_dma_model u_dma (.clk_i(clk), .reset_n_i(reset_n), .req_i(req), .data_i(rdata),
        .gap_i(gap), .ack_o(ack), .byte_o(bd), .byte_valid_o(bv));
    always #5 clk = ~clk;
    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    function automatic logic [7:0] pat(input int f, input int k);
        return 8'(f * 16 + k);
    endfunction : pat
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask : check
    task automatic summarize();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : summarize
    task automatic send(input int f, input int len);
        for (int k = 0; k < len; k++) begin
            @(posedge clk);
            rx_wr <= '{valid: 1'b1, data: pat(f, k), last: k == len - 1};
        end
        @(posedge clk);
        rx_wr <= '0;
    endtask : send
    // watch irq and request, take bytes from the dma model
    task automatic watch(input int f, input int len, input int n);
        int k;
        k = 0;
        si = 1'b0;
        sr = 1'b0;
        for (int t = 0; t < n && !(dma_mode ? k == len : si); t++) begin
            @(negedge clk);
            si = si | irq;
            sr = sr | req;
            if (bv && k < len) begin
                check(16'(bd), 16'(pat(f, k)));
                k++;
            end
        end
        if (dma_mode) check(16'(k), 16'(len));
    endtask : watch
    task automatic host_read(input int f, input int len);
        for (int k = 0; k < len; k++) begin
            @(posedge clk);
            rx_rd <= 1'b1;
            @(posedge clk);
            rx_rd <= 1'b0;
            @(negedge clk);
            check(16'(rdata), 16'(pat(f, k)));
        end
    endtask : host_read
    task automatic pulse_cmd(input hsf_cmd_t c);
        @(posedge clk);
        cmd <= c;
        @(posedge clk);
        cmd <= '0;
    endtask : pulse_cmd
    task automatic catch3(input logic sel);
        si = 1'b0;
        repeat (3) begin
            @(negedge clk);
            si = si | (sel ? ovf : rdy);
        end
    endtask : catch3
    // hang guard
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            summarize();
        end
    end
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        reset_n <= 1'b0;
        repeat (20) @(posedge clk);
        reset_n <= 1'b1;
        @(negedge clk);
        check({9'h000, irq, req, ovf, rdy, txv, und, txq}, 16'h0000);
        foreach (rows[i]) begin
            @(posedge clk);
            dma_mode <= rows[i].dma;
            gap <= 4'(rows[i].gap);
            fork
                send(i, rows[i].len);
                watch(i, rows[i].len, 600);
            join
            check(16'(si), 16'(rows[i].irq));
            check(16'(sr), 16'(rows[i].req));
            if (!rows[i].dma) begin
                host_read(i, rows[i].len);
                pulse_cmd(3'b100);
            end
            repeat (4) @(negedge clk);
            check(16'(req), 16'h0000);
        end
        // a held half keeps the next frame's irq back until released
        @(posedge clk);
        dma_mode <= 1'b0;
        fork send(8, 3); watch(8, 3, 40); join
        host_read(8, 3);
        fork send(9, 2); watch(9, 2, 40); join
        check(16'(si), 16'h0000);
        pulse_cmd(3'b100);
        watch(9, 0, 8);
        check(16'(si), 16'h0001);
        host_read(9, 2);
        pulse_cmd(3'b100);
        // both halves full, a further byte is refused
        fork send(10, 32); watch(10, 32, 40); join
        send(11, 32);
        send(12, 1);
        catch3(1'b1);
        check(16'(si), 16'h0001);
        pulse_cmd(3'b100);
        watch(11, 0, 8);
        host_read(11, 2);
        pulse_cmd(3'b100);
        // transmit flush, fill and serial drain
        pulse_cmd(3'b001);
        catch3(1'b0);
        check(16'(si), 16'h0001);
        for (int k = 0; k < 3; k++) begin
            @(posedge clk);
            tx_wr <= 1'b1;
            tx_wdata <= pat(13, k);
        end
        @(posedge clk);
        tx_wr <= 1'b0;
        pulse_cmd(3'b010);
        repeat (3) @(posedge clk);
        for (int k = 0; k < 3; k++) begin
            tx_rd <= 1'b1;
            @(posedge clk);
            tx_rd <= 1'b0;
            @(negedge clk);
            check({6'h00, txv, txl, txd}, {6'h00, 1'b1, k == 2, pat(13, k)});
            @(posedge clk);
        end
        check(16'(und), 16'h0000);
        summarize();
    end
endmodule : hsf_buffer_tb
